// ===== design/eba_regs.vh
// register offsets, field positions, reset values and timing counts of the eeprom access port
// assumes inclusion by bare name from the design files
`ifndef EBA_REGS_VH
`define EBA_REGS_VH

// ---------------------------------------------------------------
// io register offsets (byte address inside the io window)
// ---------------------------------------------------------------
`define EBA_OFS_CTRL         6'h1F
`define EBA_OFS_DATA         6'h20
`define EBA_OFS_ADDR_LOW     6'h21
`define EBA_OFS_ADDR_HIGH    6'h22

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define EBA_BIT_READ         0
`define EBA_BIT_WRITE        1
`define EBA_BIT_MASTER       2

// ---------------------------------------------------------------
// sizes and reset values
// ---------------------------------------------------------------
`define EBA_DEPTH            512
`define EBA_AW               9
`define EBA_DATA_RESET       8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define EBA_ARM_CYCLES       3'h4
`define EBA_READ_STALL       3'h4
`define EBA_WRITE_STALL      3'h2
`define EBA_CLK_NS           10
`define EBA_WRITE_TIME_US    3300
// write time in clock cycles, sized to the timer: 3300 us at 10 ns
`define EBA_WRITE_CYCLES     22'h050910

`endif

// ===== design/eba_mem.v
// byte-wide storage array standing in for the eeprom cells
// assumes one clock; read data are registered, so data appear one edge after the read
`timescale 1ns/10ps
`include "eba_regs.vh"

module eba_mem (
    input  wire                    core_clk,  // system clock
    input  wire                    wr_en,     // write the addressed byte
    input  wire                    rd_en,     // fetch the addressed byte
    input  wire [`EBA_AW-1:0]      addr,      // linear byte address
    input  wire [7:0]              wdata,     // byte to store
    output reg  [7:0]              rdata      // fetched byte
);

    reg [7:0] cells [0:`EBA_DEPTH-1];

    // no reset: contents are nonvolatile by intent
    always @(posedge core_clk) begin
        if (wr_en) begin
            cells[addr] <= wdata;
        end
        if (rd_en) begin
            rdata <= cells[addr];
        end
    end

endmodule

// ===== design/eba_timer.v
// self-timed write duration counter
// assumes start is a one-cycle pulse and is not raised while busy
`timescale 1ns/10ps
`include "eba_regs.vh"

module eba_timer #(
    parameter [21:0] WRITE_CYCLES = `EBA_WRITE_CYCLES
) (
    input  wire        core_clk,  // system clock
    input  wire        rstn,      // async reset, active low
    input  wire        start,     // begin a write period
    output wire        busy,      // write period running
    output wire        done       // one-cycle pulse at end
);

    reg [21:0] count;

    assign busy = (count != 22'h000000);
    assign done = (count == 22'h000001);

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= 22'h000000;
        end else if (start) begin
            count <= WRITE_CYCLES;
        end else if (busy) begin
            count <= count - 22'h000001;
        end
    end

endmodule

// ===== design/eba_port.v
// processor-side access port to a 512-byte data eeprom
// assumes the core issues one io access per cycle and honours stall
`timescale 1ns/10ps
`include "eba_regs.vh"

module eba_port #(
    parameter [21:0] WRITE_CYCLES = `EBA_WRITE_CYCLES
) (
    input  wire        core_clk,   // system clock
    input  wire        rstn,       // async reset, active low
    input  wire [5:0]  io_addr,    // io register address
    input  wire        io_wr,      // io write strobe
    input  wire        io_rd,      // io read strobe
    input  wire [7:0]  io_wdata,   // io write data
    output reg  [7:0]  io_rdata,   // io read data
    output wire        cpu_stall   // hold the core
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_READ  = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;

    reg  [2:0]          state;
    reg  [2:0]          next_state;
    reg  [`EBA_AW-1:0]  eeprom_byte_address;
    reg  [7:0]          eeprom_data_byte;
    reg                 master_write_enable;
    reg  [2:0]          arm_count;
    reg  [2:0]          stall_count;
    reg                 read_pending;
    wire                write_strobe;
    wire                prog_busy;
    wire [7:0]          mem_rdata;

    wire wr_ctrl  = io_wr && (io_addr == `EBA_OFS_CTRL);
    wire wr_data  = io_wr && (io_addr == `EBA_OFS_DATA);
    wire wr_low   = io_wr && (io_addr == `EBA_OFS_ADDR_LOW);
    wire wr_high  = io_wr && (io_addr == `EBA_OFS_ADDR_HIGH);

    // ---------------------------------------------------------------
    // triggers
    // ---------------------------------------------------------------
    // a write needs the arm bit still live and no write running
    wire go_write = wr_ctrl && io_wdata[`EBA_BIT_WRITE] && master_write_enable
                    && !prog_busy && (state == ST_IDLE);
    // reads are refused while programming
    wire go_read  = wr_ctrl && io_wdata[`EBA_BIT_READ] && !prog_busy
                    && !go_write && (state == ST_IDLE);

    // ---------------------------------------------------------------
    // arming window
    // ---------------------------------------------------------------
    // arm set with write strobe clear, as the documented sequence asks
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            master_write_enable <= 1'b0;
            arm_count           <= 3'h0;
        end else if (wr_ctrl && io_wdata[`EBA_BIT_MASTER]
                     && !io_wdata[`EBA_BIT_WRITE]) begin
            master_write_enable <= 1'b1;
            arm_count           <= `EBA_ARM_CYCLES;
        end else if (go_write) begin
            master_write_enable <= 1'b0;
            arm_count           <= 3'h0;
        end else if (arm_count != 3'h0) begin
            arm_count <= arm_count - 3'h1;
            if (arm_count == 3'h1) begin
                master_write_enable <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // address and data registers
    // ---------------------------------------------------------------
    // address has no reset: its value is undefined until software loads it
    always @(posedge core_clk) begin
        if (wr_low && !prog_busy) begin
            eeprom_byte_address[7:0] <= io_wdata;
        end
        if (wr_high && !prog_busy) begin
            eeprom_byte_address[8] <= io_wdata[0];
        end
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            eeprom_data_byte <= `EBA_DATA_RESET;
        end else if (read_pending) begin
            eeprom_data_byte <= mem_rdata;
        end else if (wr_data) begin
            eeprom_data_byte <= io_wdata;
        end
    end

    // ---------------------------------------------------------------
    // stall sequencer
    // ---------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (go_read) begin
                    next_state = ST_READ;
                end else if (go_write) begin
                    next_state = ST_WRITE;
                end
            end
            ST_READ: begin
                if (stall_count == 3'h1) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (stall_count == 3'h1) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state        <= ST_IDLE;
            stall_count  <= 3'h0;
            read_pending <= 1'b0;
        end else begin
            state        <= next_state;
            read_pending <= go_read;
            if (go_read) begin
                stall_count <= `EBA_READ_STALL;
            end else if (go_write) begin
                stall_count <= `EBA_WRITE_STALL;
            end else if (stall_count != 3'h0) begin
                stall_count <= stall_count - 3'h1;
            end
        end
    end

    // stall covers the cycles after the triggering access
    assign cpu_stall = (stall_count != 3'h0);

    // ---------------------------------------------------------------
    // self-timed programming
    // ---------------------------------------------------------------
    eba_timer #(
        .WRITE_CYCLES (WRITE_CYCLES)
    ) u_timer (
        .core_clk (core_clk),
        .rstn     (rstn),
        .start    (go_write),
        .busy     (prog_busy),
        .done     ()
    );

    // strobe reads as one for the whole programming period
    assign write_strobe = prog_busy;

    eba_mem u_mem (
        .core_clk (core_clk),
        .wr_en    (go_write),
        .rd_en    (go_read),
        .addr     (eeprom_byte_address),
        .wdata    (eeprom_data_byte),
        .rdata    (mem_rdata)
    );

    // ---------------------------------------------------------------
    // io read mux
    // ---------------------------------------------------------------
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                `EBA_OFS_CTRL:      io_rdata <= {5'h00, master_write_enable,
                                                 write_strobe, 1'b0};
                `EBA_OFS_DATA:      io_rdata <= eeprom_data_byte;
                `EBA_OFS_ADDR_LOW:  io_rdata <= eeprom_byte_address[7:0];
                `EBA_OFS_ADDR_HIGH: io_rdata <= {7'h00, eeprom_byte_address[8]};
                default:            io_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ===== dv/eba_port_props.sv
// assertions on the io side of the eeprom access port
// assumes one clock domain and the port's async active-low reset
`timescale 1ns/10ps
`include "eba_regs.vh"

module eba_port_props (
    input logic       core_clk,  // system clock
    input logic       rstn,      // async reset, active low
    input logic [5:0] io_addr,   // io register address
    input logic       io_wr,     // io write strobe
    input logic       io_rd,     // io read strobe
    input logic [7:0] io_wdata,  // io write data
    input logic [7:0] io_rdata,  // io read data
    input logic       cpu_stall  // hold the core
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire ctl_wr = io_wr && io_addr == `EBA_OFS_CTRL;
    wire unmap  = io_addr < `EBA_OFS_CTRL || io_addr > `EBA_OFS_ADDR_HIGH;
    // tracks a write seen started and not yet seen finished by a ctrl poll
    logic wr_try, rd_ctl, prog_seen;
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_try    <= 1'b0;
            rd_ctl    <= 1'b0;
            prog_seen <= 1'b0;
        end else begin
            wr_try <= ctl_wr && io_wdata[1] && !cpu_stall;
            rd_ctl <= io_rd && io_addr == `EBA_OFS_CTRL;
            if (wr_try && cpu_stall) begin
                prog_seen <= 1'b1;
            end else if (rd_ctl && !io_rdata[1]) begin
                prog_seen <= 1'b0;
            end
        end
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    // refused triggers (busy write) leave the stall low
    a_read_stall_four: assert property (
        ctl_wr && io_wdata[1:0] == 2'b01 && !cpu_stall && !prog_seen
        |=> cpu_stall[*4] ##1 !cpu_stall) else $error("read stall not 4");
    a_write_stall_two: assert property (
        ctl_wr && io_wdata[1] && !cpu_stall
        |=> (cpu_stall[*2] ##1 !cpu_stall) or !cpu_stall) else $error("write stall not 2");
    a_stall_has_cause: assert property (
        $rose(cpu_stall) |-> $past(ctl_wr)) else $error("stall without ctrl write");
    a_stall_max_four: assert property (
        cpu_stall[*4] |=> !cpu_stall) else $error("stall longer than 4");
    a_rdata_holds: assert property (
        !io_rd |=> $stable(io_rdata)) else $error("read data moved without read");
    a_data_readback: assert property (
        io_wr && io_addr == `EBA_OFS_DATA ##3 io_rd && io_addr == `EBA_OFS_DATA
        |=> io_rdata == $past(io_wdata, 4)) else $error("data byte readback wrong");
    a_ctrl_read_bits: assert property (
        io_rd && io_addr == `EBA_OFS_CTRL
        |=> io_rdata[7:3] == 5'h00 && !io_rdata[0]) else $error("ctrl read bits wrong");
    a_high_reserved: assert property (
        io_rd && io_addr == `EBA_OFS_ADDR_HIGH
        |=> io_rdata[7:1] == 7'h00) else $error("address high bits not zero");
    a_unmapped_zero: assert property (
        io_rd && unmap |=> io_rdata == 8'h00) else $error("unmapped read not zero");
    c_read: cover property (ctl_wr && io_wdata[1:0] == 2'b01 ##1 cpu_stall);
    c_write: cover property (ctl_wr && io_wdata[1] ##1 cpu_stall);
    c_unmap: cover property (io_rd && unmap);
endmodule

// ===== dv/eba_core_model.sv
// core model issuing io register accesses to the eeprom port
// assumes cpu_stall has settled by the falling clock edge
`timescale 1ns/10ps

module eba_core_model (
    input  logic       core_clk,   // system clock
    input  logic       cpu_stall,  // hold from the port
    input  logic [7:0] io_rdata,   // read data
    output logic [5:0] io_addr,    // io register address
    output logic       io_wr,      // io write strobe
    output logic       io_rd,      // io read strobe
    output logic [7:0] io_wdata    // io write data
);
    initial begin
        io_addr  = 6'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end
    // ---------------------------------------------------------------
    // one access; idle adds spare cycles, used to age the arm window
    // ---------------------------------------------------------------
    task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       input int idle, output logic [7:0] q);
        @(negedge core_clk);
        while (cpu_stall !== 1'b0) @(negedge core_clk); // never issue into a stall
        repeat (idle + 1) @(posedge core_clk);
        io_addr  <= a;
        io_wr    <= wr;
        io_rd    <= !wr;
        io_wdata <= d;
        @(posedge core_clk);
        io_wr    <= 1'b0;
        io_rd    <= 1'b0;
        io_addr  <= ~a; // released lines must not look like the last value
        io_wdata <= ~d;
        @(negedge core_clk);
        q = io_rdata;
    endtask
endmodule

// ===== dv/eba_port_test.sv
// self-checking bench for the eeprom access port, core model in front
// assumes a short write time parameter so busy polling stays brief
`timescale 1ns/10ps
`include "eba_regs.vh"

module eba_port_test;
    logic       core_clk, rstn, io_wr, io_rd, cpu_stall;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, q, d, hi;
    logic [8:0] a, aq [0:5];
    logic [7:0] shadow [0:511];
    logic [31:0] seed;
    int         n_errors, check_count, cycles, stall_cyc, s0, i;

    eba_port #(.WRITE_CYCLES(22'd20)) dut (.core_clk(core_clk), .rstn(rstn),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .cpu_stall(cpu_stall));
    eba_core_model cpu (.core_clk(core_clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cpu_stall === 1'b1) stall_cyc++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop;
        end
    end
    // ---------------------------------------------------------------
    // expectations and helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] exp_high(input logic [7:0] w);
        return {7'h00, w[0]};
    endfunction
    function automatic logic [7:0] exp_take(input int k);
        return (k == 0 || k == 4) ? 8'h02 : 8'h00;
    endfunction
    task automatic wr(input logic [5:0] ad, input logic [7:0] v, input int idle = 0);
        logic [7:0] r;
        cpu.acc(1'b1, ad, v, idle, r);
    endtask
    task automatic rd(input logic [5:0] ad, output logic [7:0] r);
        cpu.acc(1'b0, ad, 8'h00, 0, r);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic wait_idle;
        logic [7:0] r;
        int n;
        n = 0;
        do begin
            rd(`EBA_OFS_CTRL, r);
            n++;
        end while (r[1] !== 1'b0 && n < 40);
        chk(8'(n < 40), 8'h01);
    endtask
    task automatic set_addr(input logic [8:0] ad, input logic [7:0] h);
        wr(`EBA_OFS_ADDR_LOW, ad[7:0]);
        wr(`EBA_OFS_ADDR_HIGH, {h[7:1], ad[8]});
    endtask
    task report_and_stop;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        seed = 32'hbe869ba9;
        rstn = 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`EBA_OFS_DATA, q);
        chk(q, `EBA_DATA_RESET);
        rd(`EBA_OFS_CTRL, q);
        chk(q, 8'h00);
        rd(6'h05, q);
        chk(q, 8'h00);
        for (i = 0; i < 6; i++) begin
            a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
            d = 8'($random(seed));
            hi = 8'($random(seed));
            aq[i] = a;
            set_addr(a, hi);
            rd(`EBA_OFS_ADDR_HIGH, q);
            chk(q, exp_high({hi[7:1], a[8]}));
            rd(`EBA_OFS_ADDR_LOW, q);
            chk(q, a[7:0]);
            wr(`EBA_OFS_DATA, d);
            rd(`EBA_OFS_DATA, q);
            chk(q, d);
            wr(`EBA_OFS_CTRL, 8'h04);
            s0 = stall_cyc;
            wr(`EBA_OFS_CTRL, 8'h02);
            rd(`EBA_OFS_CTRL, q);
            chk(q & 8'h02, 8'h02);
            chk(8'(stall_cyc - s0), 8'h02);
            wr(`EBA_OFS_ADDR_LOW, ~a[7:0]);
            s0 = stall_cyc;
            wr(`EBA_OFS_CTRL, 8'h01);
            rd(`EBA_OFS_ADDR_LOW, q);
            chk(q, a[7:0]);
            chk(8'(stall_cyc - s0), 8'h00);
            shadow[a] = d;
            wait_idle;
        end
        for (i = 0; i < 6; i++) begin
            set_addr(aq[i], 8'hFE);
            s0 = stall_cyc;
            wr(`EBA_OFS_CTRL, 8'h01);
            rd(`EBA_OFS_DATA, q);
            chk(q, shadow[aq[i]]);
            chk(8'(stall_cyc - s0), 8'h04);
        end
        // arm aged to its last live edge, one past it, missing, set with the strobe,
        // and read plus write bits together while armed, where the write wins
        for (i = 0; i < 5; i++) begin
            set_addr(9'h100 + 9'(i), 8'h00);
            if (i < 2 || i == 4) wr(`EBA_OFS_CTRL, 8'h04);
            s0 = stall_cyc;
            wr(`EBA_OFS_CTRL, (i == 3) ? 8'h06 : (i == 4) ? 8'h03 : 8'h02,
               (i == 0) ? 1 : (i == 4) ? 0 : 2);
            rd(`EBA_OFS_CTRL, q);
            chk(q & 8'h02, exp_take(i));
            chk(8'(stall_cyc - s0), exp_take(i));
            wait_idle;
        end
        report_and_stop;
    end
endmodule

bind eba_port eba_port_props props (.core_clk(core_clk), .rstn(rstn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .cpu_stall(cpu_stall));
